// ==== core/zcb_unit.sv ====
/*
 Compare-against-zero branch unit: decodes, evaluates and resolves the branch.
 Assumes the pipeline supplies the source register value in the branch cycle,
 advances one instruction per cycle while issue is valid, and applies redirect
 and cancel outputs in the next instruction cycle (the delay slot).
 Assumes the register file applies wb_q at the edge after it stands, so a
 source of register 31 is read before the link value overwrites it.
 Assumes mode64 is steady while a branch is in flight.
*/
`timescale 1ns/1ps
module zcb_unit (
  input  wire logic                    core_clk,     // Core clock, 25 MHz
  input  wire logic                    rst_b,        // Async reset, active low
  input  wire logic                    mode64,       // High for 64-bit operation
  input  wire zcb_pkg::zcb_issue_t     issue,        // Instruction in its branch cycle
  output logic                         is_branch_q,  // Branch of this group was decoded
  output logic                         redirect_q,   // Load PC with target now
  output logic [zcb_pkg::XLEN-1:0]     target_q,     // Computed branch target
  output logic                         cancel_delay_slot_q, // Discard delay-slot instr
  output zcb_pkg::zcb_wb_t             wb_q,         // Link write to register file
  output logic                         exception_q   // Never raised by these branches
);
  import zcb_pkg::*;

  zcb_kind_t       kind;
  logic [5:0]      opcode;
  logic [4:0]      subcode;
  logic [4:0]      src_idx;
  logic            sign_bit;
  logic            is_zero;
  logic            taken;
  logic            likely;
  logic [XLEN-1:0] ofs_ext;
  logic [XLEN-1:0] slot_pc;
  logic [XLEN-1:0] target_d;
  logic [XLEN-1:0] link_d;
  logic            sign32;
  logic            sign64;
  logic            zero32;
  logic            zero64;
  logic [XLEN-1:0] target_full;

  assign opcode  = issue.word[OP_HI:OP_LO];
  assign subcode = issue.word[SUB_HI:SUB_LO];
  assign src_idx = issue.word[SRC_HI:SRC_LO];

  // Decode; unknown words fall to none so nothing else in the pipe is disturbed
  always_comb begin
    kind = ZCB_NONE;
    if (issue.valid) begin
      case (opcode)
        OP_GT_ZERO_LIKELY: begin
          kind = ZCB_GT_Z_LIKELY;
        end
        OP_LE_ZERO_LIKELY: begin
          kind = ZCB_LE_Z_LIKELY;
        end
        OP_LE_ZERO: begin
          // A nonzero subcode is another instruction, not a variant of this one
          if (subcode == SUB_ZERO) begin
            kind = ZCB_LE_Z;
          end else begin
            kind = ZCB_NONE;
          end
        end
        OP_IMM_GROUP: begin
          case (subcode)
            SUB_LT_ZERO: begin
              kind = ZCB_LT_Z;
            end
            SUB_LT_ZERO_LINK: begin
              kind = ZCB_LT_Z_LINK;
            end
            default: begin
              kind = ZCB_NONE;
            end
          endcase
        end
        default: begin
          kind = ZCB_NONE;
        end
      endcase
    end
  end

  // Both widths are formed side by side; the mode only picks one
  assign sign32 = issue.src_value[SIGN32];
  assign sign64 = issue.src_value[SIGN64];
  assign zero32 = (issue.src_value[SIGN32:0] == '0);
  assign zero64 = (issue.src_value == '0);

  // Sign and zero test at the active width; 32-bit mode ignores the upper word
  always_comb begin
    if (mode64) begin
      sign_bit = sign64;
      is_zero  = zero64;
    end else begin
      sign_bit = sign32;
      is_zero  = zero32;
    end
  end

  // Taken condition per kind; same form in both modes on purpose
  always_comb begin
    taken  = 1'h0;
    likely = 1'h0;
    case (kind)
      ZCB_GT_Z_LIKELY: begin
        taken  = !sign_bit && !is_zero;
        likely = 1'h1;
      end
      ZCB_LE_Z: begin
        taken  = sign_bit || is_zero;
        likely = 1'h0;
      end
      ZCB_LE_Z_LIKELY: begin
        taken  = sign_bit || is_zero;
        likely = 1'h1;
      end
      ZCB_LT_Z: begin
        taken  = sign_bit;
        likely = 1'h0;
      end
      ZCB_LT_Z_LINK: begin
        taken  = sign_bit;
        likely = 1'h0;
      end
      default: begin
        taken  = 1'h0;
        likely = 1'h0;
      end
    endcase
  end

  // Target relative to the delay slot; 32-bit mode keeps the upper word a sign copy
  assign ofs_ext = {{(XLEN-IMM_W-OFS_SHIFT){issue.word[IMM_W-1]}},
                    issue.word[IMM_W-1:0], {OFS_SHIFT{1'b0}}};
  assign slot_pc     = issue.pc + SLOT_OFFSET;
  assign target_full = slot_pc + ofs_ext;

  // In 32-bit mode the sum wraps at 32 bits and the upper word copies bit 31
  always_comb begin
    if (mode64) begin
      target_d = target_full;
    end else begin
      target_d = {{(XLEN-SIGN32-1){target_full[SIGN32]}}, target_full[SIGN32:0]};
    end
  end
  assign link_d = issue.pc + LINK_OFFSET;

  // Branch decode flag
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      is_branch_q <= 1'b0;
    end else begin
      is_branch_q <= (kind != ZCB_NONE);
    end
  end

  // Redirect lands one cycle later, while the delay slot executes, so the slot runs once
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      redirect_q <= 1'h0;
    end else begin
      redirect_q <= taken;
    end
  end

  // Target is captured every cycle; it only means something beside a redirect
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      target_q <= '0;
    end else begin
      target_q <= target_d;
    end
  end

  // Cancel only for likely forms that fall through
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cancel_delay_slot_q <= 1'b0;
    end else begin
      cancel_delay_slot_q <= likely && !taken;
    end
  end

  // Link write is unconditional; a source of register 31 is still read first
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_q.en   <= 1'h0;
      wb_q.idx  <= '0;
      wb_q.data <= '0;
    end else begin
      wb_q.en   <= (kind == ZCB_LT_Z_LINK);
      wb_q.idx  <= LINK_REG;
      wb_q.data <= link_d;
    end
  end

  // No exception path exists for this group, not even for a register 31 source
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      exception_q <= 1'b0;
    end else begin
      exception_q <= 1'b0;
    end
  end
endmodule

// ==== pkg/zcb_pkg.sv ====
/*
 Shared constants and carrier types for the compare-against-zero branch unit.
 Assumes a 32-bit instruction word and a 64-bit datapath.
*/
package zcb_pkg;
  localparam int unsigned XLEN      = 64;
  localparam int unsigned IMM_W     = 16;
  localparam int unsigned OP_HI     = 31;
  localparam int unsigned OP_LO     = 26;
  localparam int unsigned SRC_HI    = 25;
  localparam int unsigned SRC_LO    = 21;
  localparam int unsigned SUB_HI    = 20;
  localparam int unsigned SUB_LO    = 16;
  localparam int unsigned SIGN32    = 31;
  localparam int unsigned SIGN64    = 63;
  localparam int unsigned OFS_SHIFT = 2;

  localparam logic [5:0] OP_GT_ZERO_LIKELY = 6'h17;
  localparam logic [5:0] OP_LE_ZERO_LIKELY = 6'h16;
  localparam logic [5:0] OP_LE_ZERO        = 6'h06;
  localparam logic [5:0] OP_IMM_GROUP      = 6'h01;
  localparam logic [4:0] SUB_LT_ZERO       = 5'h00;
  localparam logic [4:0] SUB_LT_ZERO_LINK  = 5'h10;
  localparam logic [4:0] SUB_ZERO          = 5'h00;

  localparam logic [4:0]      LINK_REG    = 5'h1F;
  localparam logic [XLEN-1:0] LINK_OFFSET = 64'h0000_0000_0000_0008;
  localparam logic [XLEN-1:0] SLOT_OFFSET = 64'h0000_0000_0000_0004;

  // Decoded branch kinds
  typedef enum logic [2:0] {
    ZCB_NONE         = 3'b000,
    ZCB_GT_Z_LIKELY  = 3'b001,
    ZCB_LE_Z         = 3'b010,
    ZCB_LE_Z_LIKELY  = 3'b011,
    ZCB_LT_Z         = 3'b100,
    ZCB_LT_Z_LINK    = 3'b101
  } zcb_kind_t;

  // Instruction issued to the unit
  typedef struct packed {
    logic            valid;
    logic [31:0]     word;
    logic [XLEN-1:0] pc;
    logic [XLEN-1:0] src_value;
  } zcb_issue_t;

  // Register write-back request
  typedef struct packed {
    logic            en;
    logic [4:0]      idx;
    logic [XLEN-1:0] data;
  } zcb_wb_t;
endpackage

// ==== sim/zcb_unit_sva.sv ====
/* Port checker for the zero-compare branch unit.
 Assumes one core clock and the active-low reset of that clock. */
`timescale 1ns/1ps
module zcb_unit_sva (
  input wire logic                    core_clk,            // Core clock
  input wire logic                    rst_b,               // Reset, active low
  input wire logic                    mode64,              // Width mode
  input wire zcb_pkg::zcb_issue_t     issue,               // Issued word
  input wire logic                    is_branch_q,         // Decoded
  input wire logic                    redirect_q,          // Taken
  input wire logic [zcb_pkg::XLEN-1:0] target_q,           // Target
  input wire logic                    cancel_delay_slot_q, // Slot cancel
  input wire zcb_pkg::zcb_wb_t        wb_q,                // Link write
  input wire logic                    exception_q          // Exception
);
  import zcb_pkg::*;
  logic sgn;
  logic [XLEN-1:0] tgt64;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Sign as seen in the current width mode
  assign sgn = mode64 ? issue.src_value[SIGN64] : issue.src_value[SIGN32];
  // Full-width target of the word now on issue, for the 64-bit check
  assign tgt64 = issue.pc + SLOT_OFFSET + {{46{issue.word[15]}}, issue.word[15:0], 2'h0};
  // Requests of the less-than-zero pair, answered one edge later
  sequence s_ltz; issue.valid && issue.word[31:26] == OP_IMM_GROUP && issue.word[20:16] == SUB_LT_ZERO; endsequence
  sequence s_link; issue.valid && issue.word[31:26] == OP_IMM_GROUP && issue.word[20:16] == SUB_LT_ZERO_LINK; endsequence
  chk_no_exception: assert property (exception_q == 1'h0) else $error("exception raised");
  chk_link_write: assert property (s_link |=> wb_q.en && wb_q.idx == LINK_REG &&
    wb_q.data == $past(issue.pc) + LINK_OFFSET) else $error("bad link write");
  chk_ltz_taken: assert property ((s_ltz or s_link) |=> is_branch_q && redirect_q == $past(sgn))
    else $error("bad lt taken");
  chk_gt_decode: assert property (issue.valid && issue.word[31:26] == OP_GT_ZERO_LIKELY |=>
    is_branch_q && redirect_q != cancel_delay_slot_q) else $error("gt not decoded");
  chk_le_decode: assert property (issue.valid && issue.word[31:26] == OP_LE_ZERO_LIKELY |=>
    is_branch_q && redirect_q != cancel_delay_slot_q) else $error("le not decoded");
  chk_cancel_only: assert property (cancel_delay_slot_q |-> is_branch_q && !redirect_q)
    else $error("bad cancel");
  chk_idle_quiet: assert property (!issue.valid |=> !is_branch_q && !redirect_q && !wb_q.en)
    else $error("pulse without issue");
  chk_target_sum: assert property (issue.valid && mode64 |=> !is_branch_q || target_q ==
    $past(tgt64)) else $error("bad target");
  chk_le_plain: assert property (issue.valid && issue.word[31:26] == OP_LE_ZERO &&
    issue.word[20:16] == SUB_ZERO |=> is_branch_q && !cancel_delay_slot_q) else $error("le plain not decoded");
endmodule
bind zcb_unit zcb_unit_sva chk_u (.core_clk(core_clk), .rst_b(rst_b), .mode64(mode64), .issue(issue),
  .is_branch_q(is_branch_q), .redirect_q(redirect_q), .target_q(target_q),
  .cancel_delay_slot_q(cancel_delay_slot_q), .wb_q(wb_q), .exception_q(exception_q));

// ==== sim/zcb_pipe_model.sv ====
/* Register file model of the pipeline side.
 Reads are combinational; link writes land on the next rising edge. */
`timescale 1ns/1ps
module zcb_pipe_model (
  input  wire logic                 core_clk, // Core clock
  input  wire zcb_pkg::zcb_wb_t     wb,       // Write-back from the unit
  input  wire logic [4:0]           ridx,     // Source register field
  output logic [zcb_pkg::XLEN-1:0]  rval      // Source register value
);
  import zcb_pkg::*;
  logic [XLEN-1:0] rf [32];
  // Plain always so the bench may preload entries; link write wins over r31
  always @(posedge core_clk)
    if (wb.en) rf[wb.idx] <= wb.data;
  assign rval = rf[ridx];
endmodule

// ==== sim/zcb_unit_test.sv ====
/* Self-checking bench for the zero-compare branch unit.
 Drives issue at falling edges; the model supplies register values. */
`timescale 1ns/1ps
module zcb_unit_test;
  import zcb_pkg::*;
  logic core_clk, rst_b, mode64, vld, br, red, can, exc;
  logic [31:0] word;
  logic [63:0] pc, tgt, rv;
  zcb_issue_t issue;
  zcb_wb_t wb;
  int fails = 0, num_checks = 0;
  logic [63:0] vals [4] = '{64'h0, 64'h1, 64'h8000_0000, 64'h8000_0000_0000_0000};
  logic [31:0] ops [5] = '{32'h5C00_0000, 32'h1800_0000, 32'h5800_0000, 32'h0400_0000, 32'h0410_0000};
  assign issue = '{vld, word, pc, rv};
  zcb_unit dut_u (.core_clk(core_clk), .rst_b(rst_b), .mode64(mode64), .issue(issue), .is_branch_q(br),
    .redirect_q(red), .target_q(tgt), .cancel_delay_slot_q(can), .wb_q(wb), .exception_q(exc));
  zcb_pipe_model pm (.core_clk(core_clk), .wb(wb), .ridx(word[25:21]), .rval(rv));
  // Clock, 40 ns period
  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end
  task chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Called at a falling edge, so calls run back to back
  task issue_one(input logic [31:0] w, input logic m, input logic [63:0] p, input logic [2:0] exp);
    {vld, word, mode64, pc} = {1'h1, w, m, p};
    @(negedge core_clk);
    chk({br, red, can}, exp);
    chk(exc, 64'h0);
  endtask
  task idle;
    vld = 1'h0;
    @(negedge core_clk);
    chk({br, red, can, wb.en}, 64'h0);
  endtask
  // Every kind against zero, one, bit 31 and bit 63, in both modes
  task t_conditions;
    logic s, z, t;
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 5; k++) begin
        for (int i = 0; i < 4; i++) begin
          pm.rf[5] = vals[i];
          s = m ? vals[i][63] : vals[i][31];
          z = m ? vals[i] == 64'h0 : vals[i][31:0] == 32'h0;
          t = k == 0 ? !s && !z : k < 3 ? s || z : s;
          issue_one(ops[k] | 32'h00A0_FFFE, m[0], 64'h1000, {1'h1, t, (k == 0 || k == 2) && !t});
          chk(tgt, 64'h0FFC);
          chk(wb.en, k == 4);
        end
      end
    end
  endtask
  // Target crossing bit 31 sign-extends only in 32-bit mode
  task t_target;
    pm.rf[5] = 64'h0;
    issue_one(32'h18A0_0004, 1'h0, 64'h7FFF_FFF0, 3'h6);
    chk(tgt, 64'hFFFF_FFFF_8000_0004);
    issue_one(32'h18A0_0004, 1'h1, 64'h7FFF_FFF0, 3'h6);
    chk(tgt, 64'h0000_0000_8000_0004);
  endtask
  task t_refuse;
    issue_one(32'h18A1_FFFE, 1'h1, 64'h1000, 3'h0);
    issue_one(32'h04A1_FFFE, 1'h1, 64'h1000, 3'h0);
    issue_one(32'h10A0_FFFE, 1'h1, 64'h1000, 3'h0);
    idle;
  endtask
  // Link with r31 as source clobbers it; the next use sees the link value
  task t_link;
    pm.rf[31] = 64'h8000_0000_0000_0000;
    issue_one(32'h07F0_0003, 1'h1, 64'h2000, 3'h6);
    chk({wb.idx, wb.data}, {5'h1F, 64'h2008});
    idle;
    chk(pm.rf[31], 64'h2008);
    issue_one(32'h07F0_0003, 1'h1, 64'h3000, 3'h4);
    chk(wb.data, 64'h3008);
  endtask
  // Mid-run reset clears every pulse at once; the first edge after release is live
  task t_reset;
    pm.rf[5] = 64'hFFFF_FFFF_FFFF_FFFF;
    issue_one(32'h04B0_0003, 1'h1, 64'h4000, 3'h6);
    rst_b = 1'h0;
    #1;
    chk({br, red, can, wb.en, exc}, 64'h0);
    chk(wb.data | tgt, 64'h0);
    @(negedge core_clk);
    chk({br, red, can, wb.en}, 64'h0);
    rst_b = 1'h1;
    @(negedge core_clk);
    chk({br, red, can, wb.en}, 64'hD);
    chk(wb.data, 64'h4008);
  endtask
  initial begin
    {rst_b, vld, word, mode64, pc} = '0;
    repeat (8) @(negedge core_clk);
    rst_b = 1'h1;
    t_conditions;
    t_target;
    t_refuse;
    t_link;
    t_reset;
    print_verdict;
  end
  // Run needs about 60 cycles; a thousand means a hang
  initial begin
    #40000;
    fails++;
    print_verdict;
  end
endmodule
